// ==== logic/floppy_read_pkg.sv ====
/*
 * Shared constants and types for the floppy read data sequencer: register
 * offsets, command byte layout, status bit positions, reset values, timing.
 * Assumes a single 10 MHz clock and word-aligned AHB-Lite register access.
 */
package floppy_read_pkg;
    // Register byte offsets (haddr[3:0]); haddr[11:4] must be zero.
    localparam logic [3:0]  ADDR_DATA      = 4'h0;
    localparam logic [3:0]  ADDR_STATUS    = 4'h4;
    localparam logic [3:0]  ADDR_CONFIG    = 4'h8;
    localparam logic [3:0]  ADDR_SHARED    = 4'hC;
    // Command byte layout.
    localparam logic [3:0]  CMD_LAST       = 4'h8;
    localparam logic [2:0]  RES_LAST       = 3'h6;
    localparam logic [4:0]  CODE_READ      = 5'h06;
    localparam logic [4:0]  CODE_READ_DEL  = 5'h0C;
    localparam int          MT_BIT         = 7;
    localparam int          SK_BIT         = 5;
    localparam int          BYTE_C         = 2;
    localparam int          BYTE_H         = 3;
    localparam int          BYTE_R         = 4;
    localparam int          BYTE_N         = 5;
    localparam int          BYTE_EOT       = 6;
    localparam int          BYTE_DTL       = 8;
    // Result status encoding.
    localparam logic [1:0]  IC_NORMAL      = 2'h0;
    localparam logic [1:0]  IC_ABNORMAL    = 2'h1;
    localparam logic [1:0]  IC_INVALID     = 2'h2;
    localparam int          ST1_EN         = 7;
    localparam int          ST1_DE         = 5;
    localparam int          ST1_ND         = 2;
    localparam int          ST2_CM         = 6;
    localparam int          ST2_DD         = 5;
    // Configuration register fields and reset values.
    localparam int          CFG_SEEK_BIT   = 0;
    localparam int          CFG_SETTLE_LSB = 4;
    localparam int          CFG_UNLOAD_LSB = 8;
    localparam logic        CFG_SEEK_RST   = 1'b0;
    localparam logic [3:0]  SETTLE_RST     = 4'h8;
    localparam logic [3:0]  UNLOAD_RST     = 4'hF;
    // Sector sizing.
    localparam logic [14:0] MIN_SECTOR     = 15'h0080;
    // Timing: the settle and unload counters run on a 1 ms tick.
    localparam int          CLK_NS         = 100;
    localparam int          TICK_US        = 1000;
    localparam int          TICK_CYCLES    = TICK_US * 1000 / CLK_NS;
    localparam int          TICK_W         = 14;

    typedef enum logic [6:0] {
        PH_CMD    = 7'b0000001,
        PH_SEEK   = 7'b0000010,
        PH_SETTLE = 7'b0000100,
        PH_SEARCH = 7'b0001000,
        PH_MARK   = 7'b0010000,
        PH_DATA   = 7'b0100000,
        PH_RESULT = 7'b1000000
    } phase_t;
endpackage : floppy_read_pkg

// ==== logic/pin_stage_if.sv ====
/*
 * Carrier between the pin input stage and the sequencer core.
 * Assumes both ends run on the same clock.
 */
interface pin_stage_if;
    logic index_pulse;
    logic tc_pulse;
    modport stage (output index_pulse, output tc_pulse);
    modport core  (input  index_pulse, input  tc_pulse);
endinterface : pin_stage_if

// ==== logic/pin_stage.sv ====
/*
 * Synchronises the index and terminal count pins and turns each into a
 * one-cycle pulse on its active edge.
 * Assumes both pins are asynchronous to clk and wider than two cycles.
 */
module pin_stage (
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     srst,
    // Pins
    input  wire logic     index_n,
    input  wire logic     tc_pin,
    // Core side
    pin_stage_if.stage    pins
);
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
    } sync_t;

    sync_t s;
    sync_t next_s;

    always_comb begin
        next_s    = s;
        next_s.s1 = {tc_pin, ~index_n};
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pins.index_pulse = s.s2[0] & ~s.s3[0];
    assign pins.tc_pulse    = s.s2[1] & ~s.s3[1];
endmodule : pin_stage

// ==== logic/floppy_read_data_sequencer.sv ====
/*
 * Execution engine for the read data and read deleted data commands: command
 * byte intake, implied seek, head load and settle, ID search, multi-sector
 * reading into the data stream, termination and the result bytes.
 * Assumes an AHB-Lite master, a drive read channel on clk that strobes ID
 * fields, data marks, data bytes and sector ends, and a seek engine outside.
 */
// Local design decisions: the register offsets and the AHB-Lite slave port.
module floppy_read_data_sequencer #(
    parameter int TICK_CYCLES_P = floppy_read_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output wire logic        hreadyout,
    output wire logic [31:0] hrdata,
    output wire logic        hresp,
    // Drive pins
    input  wire logic        index_n,
    input  wire logic        tc_pin,
    // Read channel
    input  wire logic        id_strobe,
    input  wire logic [31:0] id_field,
    input  wire logic        id_crc_bad,
    input  wire logic        mark_strobe,
    input  wire logic        mark_deleted,
    input  wire logic        byte_strobe,
    input  wire logic [7:0]  byte_data,
    input  wire logic        sector_end,
    input  wire logic        data_crc_bad,
    // Seek engine
    output wire logic        seek_req,
    output wire logic [7:0]  seek_cyl,
    input  wire logic        seek_done,
    input  wire logic        seek_fail,
    input  wire logic [7:0]  seek_pos,
    // Head
    output wire logic        head_load,
    output wire logic        head_side,
    // Data stream
    output wire logic [7:0]  data_out,
    output wire logic        data_valid,
    input  wire logic        data_ready
);
    import floppy_read_pkg::*;

    typedef struct packed {
        phase_t             ph;
        logic [8:0][7:0]    cmd;
        logic [3:0]         cnt;
        logic               cfg_seek;
        logic [3:0]         settle;
        logic [3:0]         unload;
        logic [7:0]         pcn;
        logic               head_up;
        logic [TICK_W-1:0]  tick;
        logic [3:0]         tmr;
        logic [3:0]         unl;
        logic               idx_seen;
        logic [7:0]         c;
        logic [7:0]         h;
        logic [7:0]         r;
        logic [14:0]        bytes;
        logic               deliv;
        logic               stop;
        logic               hold;
        logic [1:0]         ic;
        logic               se;
        logic [7:0]         st1;
        logic [7:0]         st2;
        logic [2:0]         ridx;
        logic [7:0]         dout;
        logic               dvalid;
        logic [31:0]        rdata;
        logic               wr_pend;
        logic [3:0]         wr_addr;
    } core_state_t;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES_P - 1);

    core_state_t s;
    core_state_t next_s;
    pin_stage_if pins ();

    pin_stage u_pins (
        .clk     (clk),
        .srst    (srst),
        .index_n (index_n),
        .tc_pin  (tc_pin),
        .pins    (pins)
    );

    // Next address {c, h, r}; wraps to sector 1 at the last sector number.
    function automatic logic [23:0] advance(input logic [7:0] c, input logic [7:0] h,
                                            input logic [7:0] r, input logic [7:0] last_sector_number,
                                            input logic mt);
        logic [23:0] a;
        a = {c, h, r + 8'h01};
        if (r == last_sector_number) begin
            a[7:0] = 8'h01;
            if (mt) begin
                a[15:8] = {h[7:1], ~h[0]};
            end
            if (!mt || h[0]) begin
                a[23:16] = c + 8'h01;
            end
        end
        return a;
    endfunction : advance

    // Bytes to deliver per sector.
    function automatic logic [14:0] sector_limit(input logic [7:0] n, input logic [7:0] data_length);
        logic [14:0] lim;
        lim = MIN_SECTOR << n[2:0];
        if (n == 8'h00 && data_length < 8'h80) begin
            lim = {7'h00, data_length};
        end
        return lim;
    endfunction : sector_limit

    logic tick_pulse;
    assign tick_pulse = (s.tick == TICK_LAST);

    always_comb begin
        logic        take;
        logic        finish;
        logic        want_del;
        logic        mt;
        logic        last;
        logic [23:0] adv;
        logic [4:0]  code;
        take     = hsel & htrans[1] & hready & (haddr[11:4] == 8'h00);
        finish   = 1'b0;
        want_del = (s.cmd[0][4:0] == CODE_READ_DEL);
        mt       = s.cmd[0][MT_BIT];
        last     = (s.r == s.cmd[BYTE_EOT]) && (!mt || s.h[0]);
        adv      = advance(s.c, s.h, s.r, s.cmd[BYTE_EOT], mt);
        code     = s.cmd[0][4:0];
        next_s   = s;
        next_s.tick    = tick_pulse ? '0 : s.tick + 1'b1;
        next_s.wr_pend = take & hwrite;
        next_s.wr_addr = haddr[3:0];
        if (s.dvalid && data_ready) begin
            next_s.dvalid = 1'b0;
        end

        // Register writes land in the data phase.
        if (s.wr_pend) begin
            case (s.wr_addr)
                ADDR_DATA: begin
                    if (s.ph == PH_CMD) begin
                        next_s.cmd[s.cnt] = hwdata[7:0];
                        next_s.cnt        = s.cnt + 4'h1;
                        if (s.cnt == CMD_LAST) begin
                            next_s.cnt      = 4'h0;
                            next_s.c        = s.cmd[BYTE_C];
                            next_s.h        = s.cmd[BYTE_H];
                            next_s.r        = s.cmd[BYTE_R];
                            next_s.ic       = IC_NORMAL;
                            next_s.se       = 1'b0;
                            next_s.st1      = 8'h00;
                            next_s.st2      = 8'h00;
                            next_s.stop     = 1'b0;
                            next_s.hold     = 1'b0;
                            next_s.idx_seen = 1'b0;
                            if (code != CODE_READ && code != CODE_READ_DEL) begin
                                next_s.ic = IC_INVALID;
                                finish    = 1'b1;
                            end else if (s.cfg_seek && s.cmd[BYTE_C] != s.pcn) begin
                                next_s.ph = PH_SEEK;
                            end else begin
                                next_s.ph      = s.head_up ? PH_SEARCH : PH_SETTLE;
                                next_s.head_up = 1'b1;
                                next_s.tmr     = s.settle;
                            end
                        end
                    end
                end
                ADDR_CONFIG: begin
                    next_s.cfg_seek = hwdata[CFG_SEEK_BIT];
                    next_s.settle   = hwdata[CFG_SETTLE_LSB +: 4];
                    next_s.unload   = hwdata[CFG_UNLOAD_LSB +: 4];
                end
                default: begin
                end
            endcase
        end

        // Register reads are captured at the address phase.
        if (take && !hwrite) begin
            case (haddr[3:0])
                ADDR_DATA: begin
                    next_s.rdata = 32'h0000_0000;
                    if (s.ph == PH_RESULT) begin
                        case (s.ridx)
                            3'h0:    next_s.rdata[7:0] = {s.ic, s.se, 2'b00, s.cmd[1][2:0]};
                            3'h1:    next_s.rdata[7:0] = s.st1;
                            3'h2:    next_s.rdata[7:0] = s.st2;
                            3'h3:    next_s.rdata[7:0] = s.c;
                            3'h4:    next_s.rdata[7:0] = s.h;
                            3'h5:    next_s.rdata[7:0] = s.r;
                            default: next_s.rdata[7:0] = s.cmd[BYTE_N];
                        endcase
                        next_s.ridx = s.ridx + 3'h1;
                        if (s.ridx == RES_LAST) begin
                            next_s.ph = PH_CMD;
                        end
                    end
                end
                ADDR_STATUS: begin
                    next_s.rdata = {24'h00_0000,
                                    (s.ph == PH_CMD) || (s.ph == PH_RESULT),
                                    s.ph == PH_RESULT,
                                    !((s.ph == PH_CMD) || (s.ph == PH_RESULT)),
                                    s.ph != PH_CMD,
                                    3'b000,
                                    s.ph == PH_SEEK};
                end
                ADDR_CONFIG: begin
                    next_s.rdata = {20'h0_0000, s.unload, s.settle, 3'b000, s.cfg_seek};
                end
                default: begin
                    next_s.rdata = {24'h00_0000, s.cmd[BYTE_EOT]};
                end
            endcase
        end

        if (pins.tc_pulse && (s.ph == PH_SEARCH || s.ph == PH_MARK || s.ph == PH_DATA)) begin
            next_s.stop = 1'b1;
        end

        case (s.ph)
            PH_CMD: begin
                if (s.head_up && tick_pulse) begin
                    next_s.unl = s.unl + 4'h1;
                    if (s.unl + 4'h1 >= s.unload) begin
                        next_s.head_up = 1'b0;
                    end
                end
            end
            PH_SEEK: begin
                if (seek_fail) begin
                    next_s.ic = IC_ABNORMAL;
                    next_s.se = 1'b1;
                    next_s.c  = seek_pos;
                    finish    = 1'b1;
                end else if (seek_done) begin
                    next_s.pcn     = s.c;
                    next_s.se      = 1'b1;
                    next_s.ph      = s.head_up ? PH_SEARCH : PH_SETTLE;
                    next_s.head_up = 1'b1;
                    next_s.tmr     = s.settle;
                end
            end
            PH_SETTLE: begin
                if (tick_pulse) begin
                    next_s.tmr = s.tmr - 4'h1;
                    if (s.tmr == 4'h0) begin
                        next_s.ph = PH_SEARCH;
                    end
                end
            end
            PH_SEARCH, PH_MARK: begin
                if (pins.index_pulse) begin
                    next_s.idx_seen = 1'b1;
                    if (s.idx_seen) begin
                        next_s.ic          = IC_ABNORMAL;
                        next_s.st1[ST1_ND] = 1'b1;
                        finish             = 1'b1;
                    end
                end
                if (s.ph == PH_SEARCH && id_strobe && !finish) begin
                    if (id_crc_bad) begin
                        next_s.ic          = IC_ABNORMAL;
                        next_s.st1[ST1_DE] = 1'b1;
                        next_s.st2[ST2_DD] = 1'b1;
                        finish             = 1'b1;
                    end else if (id_field == {s.c, s.h, s.r, s.cmd[BYTE_N]}) begin
                        next_s.ph = PH_MARK;
                    end
                end
                if (s.ph == PH_MARK && mark_strobe && !finish) begin
                    next_s.ph    = PH_DATA;
                    next_s.bytes = 15'h0000;
                    next_s.deliv = 1'b1;
                    if (mark_deleted != want_del) begin
                        next_s.st2[ST2_CM] = 1'b1;
                        next_s.deliv       = !s.cmd[0][SK_BIT];
                        next_s.hold        = !s.cmd[0][SK_BIT];
                    end
                end
            end
            PH_DATA: begin
                if (byte_strobe) begin
                    next_s.bytes = s.bytes + 15'h0001;
                    if (s.deliv && !s.stop &&
                        s.bytes < sector_limit(s.cmd[BYTE_N], s.cmd[BYTE_DTL])) begin
                        if (s.dvalid && !data_ready) begin
                            next_s.stop = 1'b1;
                        end else begin
                            next_s.dout   = byte_data;
                            next_s.dvalid = 1'b1;
                        end
                    end
                end
                if (sector_end) begin
                    if (data_crc_bad) begin
                        next_s.ic          = IC_ABNORMAL;
                        next_s.st1[ST1_DE] = 1'b1;
                        finish             = 1'b1;
                    end else if (s.hold) begin
                        finish = 1'b1;
                    end else begin
                        {next_s.c, next_s.h, next_s.r} = adv;
                        next_s.ph       = PH_SEARCH;
                        next_s.idx_seen = 1'b0;
                        if (s.stop || pins.tc_pulse) begin
                            finish = 1'b1;
                        end else if (last) begin
                            next_s.ic          = IC_ABNORMAL;
                            next_s.st1[ST1_EN] = 1'b1;
                            finish             = 1'b1;
                        end
                    end
                end
            end
            PH_RESULT: begin
            end
            default: begin
                next_s.ph = PH_CMD;
            end
        endcase

        if (finish) begin
            next_s.ph   = PH_RESULT;
            next_s.ridx = 3'h0;
            next_s.unl  = 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s          <= '0;
            s.ph       <= PH_CMD;
            s.cfg_seek <= CFG_SEEK_RST;
            s.settle   <= SETTLE_RST;
            s.unload   <= UNLOAD_RST;
        end else begin
            s <= next_s;
        end
    end

    // Zero-wait slave: every transfer completes with OKAY.
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = s.rdata;
    assign seek_req   = (s.ph == PH_SEEK);
    assign seek_cyl   = s.c;
    assign head_load  = s.head_up;
    assign head_side  = s.cmd[1][2] ^ s.h[0] ^ s.cmd[BYTE_H][0];
    assign data_out   = s.dout;
    assign data_valid = s.dvalid;
endmodule : floppy_read_data_sequencer

// ==== tb/floppy_read_data_sequencer_assertions.sv ====
/* Port checker for the read sequencer.
   Assumes it is bound to the sequencer top module. */
module floppy_read_data_sequencer_assertions (
    // Clock, reset and bus
    input wire logic        clk, srst, hsel, hwrite, hreadyout, hresp,
    input wire logic [1:0]  htrans,
    input wire logic [31:0] hrdata,
    // Drive, seek and stream
    input wire logic        tc_pin, byte_strobe, seek_req, seek_done, seek_fail,
    input wire logic        head_load, data_valid, data_ready,
    input wire logic [7:0]  byte_data, seek_cyl, data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // The pin stage needs three cycles, so the stop is judged from the fifth.
    sequence tc_seen;
        $rose(tc_pin) ##5 1;
    endsequence
    sequence byte_prev;
        $past(byte_strobe) && data_out == $past(byte_data);
    endsequence
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not okay");
    chk_byte_latch: assert property ($rose(data_valid) |-> byte_prev)
        else $error("stream byte differs");
    chk_stream_hold: assert property (data_valid && !data_ready && !byte_strobe
        |=> data_valid && $stable(data_out)) else $error("stream byte lost");
    chk_tc_stop: assert property (tc_seen |-> (!$rose(data_valid)) [*8])
        else $error("data after stop");
    chk_seek_quiet: assert property (seek_req |-> !data_valid)
        else $error("data during seek");
    chk_seek_held: assert property (seek_req && !seek_done && !seek_fail |=> seek_req)
        else $error("seek busy dropped");
    chk_cyl_steady: assert property (seek_req && $past(seek_req) |-> $stable(seek_cyl))
        else $error("seek target moved");
    chk_head_kept: assert property ($fell(data_valid) |-> head_load [*8])
        else $error("head dropped early");
    chk_data_head: assert property (data_valid |-> head_load)
        else $error("data without head");
    chk_read_steady: assert property (!(hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
        else $error("read data moved");
endmodule : floppy_read_data_sequencer_assertions

bind floppy_read_data_sequencer floppy_read_data_sequencer_assertions chk (.clk, .srst,
    .hsel, .hwrite, .hreadyout, .hresp, .htrans, .hrdata, .tc_pin, .byte_strobe, .seek_req,
    .seek_done, .seek_fail, .head_load, .data_valid, .data_ready, .byte_data, .seek_cyl,
    .data_out);

// ==== tb/drive_model.sv ====
/* Drive model: one 128-byte sector per revolution, index pulse, seek engine.
   Assumes run stays high while a command executes. */
module drive_model (
    // Clock and controls
    input  wire logic   clk, run, slow, seek_req,
    // Read channel and seek answer
    output logic        index_n, id_strobe, mark_strobe, byte_strobe, sector_end, seek_done,
    output logic [7:0]  byte_data,
    output logic [31:0] id_field
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_cnt = 4'h0;
    int         k;
    always @(posedge clk) begin
        wait_cnt <= seek_req ? wait_cnt + 4'h1 : 4'h0;
        seek_done <= wait_cnt == 4'h6;
    end
    // Idle lines show the inverse of their last value, never a kind leftover.
    initial begin
        {index_n, id_strobe, mark_strobe, byte_strobe, sector_end} = 5'h10;
        {byte_data, id_field} = 40'h0;
        forever begin
            @(posedge clk);
            if (run) begin
                index_n <= 1'b0;
                repeat (4) @(posedge clk);
                {index_n, id_strobe, id_field} <= {2'h3, 32'h05000100};
                @(posedge clk);
                {id_strobe, id_field} <= {1'b0, ~32'h05000100};
                repeat (2) @(posedge clk);
                mark_strobe <= 1'b1;
                @(posedge clk);
                mark_strobe <= 1'b0;
                for (k = 0; k < 128; k++) begin
                    repeat (slow ? 4 : 2) @(posedge clk);
                    {byte_strobe, byte_data} <= {1'b1, k[7:0] ^ 8'h01};
                    @(posedge clk);
                    {byte_strobe, byte_data} <= {1'b0, ~byte_data};
                end
                sector_end <= 1'b1;
                @(posedge clk);
                sector_end <= 1'b0;
                repeat (20) @(posedge clk);
            end
        end
    end
endmodule : drive_model

// ==== tb/test_floppy_read_data_sequencer.sv ====
/* Testbench: AHB-Lite master, drive model and a stream monitor fed by a queue.
   Assumes the drive presents cylinder 5, head 0, sector 1, size 0 each turn. */
module test_floppy_read_data_sequencer;
    import floppy_read_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, srst = 1, hsel = 0, hwrite = 0, data_ready = 1, tc_pin = 0;
    logic        run = 0, slow = 0, del = 0, rnd = 0, hreadyout, hresp, index_n, id_strobe;
    logic        mark_strobe, byte_strobe, sector_end, seek_req, seek_done, head_load;
    logic        head_side, data_valid, crc_bad = 0, tc_go = 0;
    logic [1:0]  htrans = 0;
    logic [7:0]  byte_data, seek_cyl, data_out, exp_q[$], res[7];
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q, id;
    int          fails = 0, checks = 0, seed = 88, k;
    floppy_read_data_sequencer #(.TICK_CYCLES_P(10)) dut (.clk, .srst, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .index_n, .tc_pin, .id_strobe, .id_field(id), .id_crc_bad(1'b0), .mark_strobe,
        .mark_deleted(del), .byte_strobe, .byte_data, .sector_end, .data_crc_bad(crc_bad),
        .seek_req, .seek_cyl, .seek_done, .seek_fail(1'b0), .seek_pos(8'h00), .head_load,
        .head_side, .data_out, .data_valid, .data_ready);
    drive_model drive (.clk, .run, .slow, .seek_req, .index_n, .id_strobe, .mark_strobe,
        .byte_strobe, .sector_end, .seek_done, .byte_data, .id_field(id));
    initial forever #50 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, want);
        end
    endtask : check
    task automatic test_done();
        $display("fails %0d checks %0d", fails, checks);
        if (fails == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // A stall lasts at most one cycle, so the slow drive never overruns.
    always @(posedge clk) begin
        data_ready <= !rnd || $random(seed) % 2 != 0 || (data_valid && !data_ready);
        if (data_valid === 1'b1 && data_ready === 1'b1)
            check({24'h0, data_out}, exp_q.size() ? {24'h0, exp_q.pop_front()} : 'x);
    end
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        {hsel, htrans, hwrite, haddr} <= {3'h6, w, a};
        for (int i = 0; i < 2; i++) begin
            if (i == 1) begin
                {hsel, htrans} <= 3'h0;
                hwdata <= d;
            end
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (hreadyout !== 1'b1 && n < 20);
            if (hreadyout !== 1'b1) begin
                fails++;
                test_done();
            end
        end
        q = hrdata;
    endtask : ahb
    task automatic run_cmd(input logic [7:0] b0, input logic [7:0] data_length, input int nb,
                           input logic sl, input logic dl);
        logic [7:0] b[9];
        b = '{b0, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h01, 8'h1B, data_length};
        for (k = 0; k < nb; k++)
            exp_q.push_back(k[7:0] ^ 8'h01);
        {slow, del, rnd, run} <= {sl, dl, sl, 1'b1};
        for (k = 0; k < 9; k++)
            ahb(1'b1, {28'h0, ADDR_DATA}, {24'h0, b[k]});
        tc_pin <= tc_go;
        k = 0;
        do begin
            ahb(1'b0, {28'h0, ADDR_STATUS}, 32'h0);
            k++;
        end while (q[6] !== 1'b1 && k < 2000);
        if (q[6] !== 1'b1) begin
            fails++;
            test_done();
        end
        {run, tc_pin} <= 2'b00;
        for (k = 0; k < 7; k++) begin
            ahb(1'b0, {28'h0, ADDR_DATA}, 32'h0);
            res[k] = q[7:0];
        end
        check(32'(exp_q.size()), 32'h0);
    endtask : run_cmd
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        ahb(1'b0, {28'h0, ADDR_CONFIG}, 32'h0);
        check(q, {20'h0, UNLOAD_RST, SETTLE_RST, 3'h0, CFG_SEEK_RST});
        ahb(1'b0, 32'h10, 32'h0);
        check(q, {20'h0, UNLOAD_RST, SETTLE_RST, 3'h0, CFG_SEEK_RST});
        ahb(1'b1, {28'h0, ADDR_CONFIG}, {20'h0, UNLOAD_RST, SETTLE_RST, 4'h1});
        run_cmd({3'h0, CODE_READ}, 8'h10, 16, 1'b0, 1'b0);
        check(res[0][7:6], IC_ABNORMAL);
        check(res[1][ST1_EN], 1'b1);
        check({res[2], res[3], res[4], res[5], res[6]}, 40'h0006000100);
        ahb(1'b0, {28'h0, ADDR_SHARED}, 32'h0);
        check(q[7:0], 8'h01);
        run_cmd({3'h0, CODE_READ_DEL}, 8'hFF, 128, 1'b1, 1'b0);
        check(res[2][ST2_CM], 1'b1);
        check({res[3], res[5]}, 16'h0501);
        run_cmd({3'h5, CODE_READ}, 8'hFF, 0, 1'b0, 1'b1);
        check(res[2][ST2_CM], 1'b1);
        check({res[0][7:6], res[1][ST1_ND]}, {IC_ABNORMAL, 1'b1});
        check({res[4], head_side}, 9'h003);
        tc_go = 1'b1;
        run_cmd({3'h0, CODE_READ}, 8'hFF, 0, 1'b0, 1'b0);
        check({res[0][7:6], res[1][ST1_EN], res[3], res[5]}, {IC_NORMAL, 17'h00601});
        tc_go = 1'b0;
        crc_bad <= 1'b1;
        run_cmd({3'h0, CODE_READ_DEL}, 8'h10, 16, 1'b0, 1'b1);
        check({res[0][7:6], res[1][ST1_DE], res[2][ST2_CM]}, {IC_ABNORMAL, 2'b10});
        run_cmd(8'h1F, 8'hFF, 0, 1'b0, 1'b0);
        check(res[0][7:6], IC_INVALID);
        test_done();
    end
endmodule : test_floppy_read_data_sequencer
